/* File: rtl/gray_pkg.sv */
package gray_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL         = 8'h02;
  localparam logic [7:0] IDX_HWIDTH       = 8'h04;
  localparam logic [7:0] IDX_LINE_EXTRA   = 8'h11;
  localparam logic [7:0] IDX_LUT_INDEX    = 8'h15;
  localparam logic [7:0] IDX_LUT_DATA     = 8'h17;
  localparam logic [7:0] IDX_STRIDE       = 8'h20;
  localparam logic [7:0] IDX_LINE_ADDR    = 8'h21;
  localparam logic [9:0] ADDR_CTRL        = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_HWIDTH      = {IDX_HWIDTH, 2'b00};
  localparam logic [9:0] ADDR_LINE_EXTRA  = {IDX_LINE_EXTRA, 2'b00};
  localparam logic [9:0] ADDR_LUT_INDEX   = {IDX_LUT_INDEX, 2'b00};
  localparam logic [9:0] ADDR_LUT_DATA    = {IDX_LUT_DATA, 2'b00};
  localparam logic [9:0] ADDR_STRIDE      = {IDX_STRIDE, 2'b00};
  localparam logic [9:0] ADDR_LINE_ADDR   = {IDX_LINE_ADDR, 2'b00};

  // Control register fields
  localparam int CTRL_BPP_LSB = 0;
  localparam int CTRL_EN_BIT  = 2;
  // LUT data register fields (red, green, blue nibbles)
  localparam int LUT_RED_LSB   = 8;
  localparam int LUT_GREEN_LSB = 4;
  localparam int LUT_BLUE_LSB  = 0;

  // Depth codes
  typedef enum logic [1:0] {
    BPP_1 = 2'b00,
    BPP_2 = 2'b01,
    BPP_4 = 2'b10,
    BPP_8 = 2'b11
  } bpp_t;

  // Reset values
  localparam bpp_t       RST_BPP        = BPP_1;
  localparam logic       RST_EN         = 1'b0;
  localparam logic [7:0] RST_HWIDTH     = 8'h14;
  localparam logic [7:0] RST_LINE_EXTRA = 8'h00;
  localparam logic [7:0] RST_LUT_INDEX  = 8'h00;
  localparam logic [3:0] RST_GREEN      = 4'h0;

  // Sizes
  localparam int GRAY_LEVELS = 16;
  localparam int GRAY_W      = 4;
  localparam int FIFO_DEPTH  = 16;
  localparam int WADDR_W     = 17;
endpackage : gray_pkg

/* File: rtl/pix_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module pix_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;
  logic         full;
  logic         empty;

  // Extra pointer bit tells full from empty
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty     = (wr_q == rd_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : pix_fifo
`default_nettype wire

/* File: rtl/gray_lut_fetch.sv */
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Gray level comes from green field only
// [R2] Exactly sixteen gray intensities supported
// [R3] No 8 bpp in gray shade
// [R4] 1 bpp: eight pixels, entries 0-1
// [R5] 2 bpp: four pixels, entries 0-3
// [R6] 4 bpp: two pixels, entries 0-15
// [R7] Software may load 0h black, Fh white
// [R8] Stride is width plus 0-255 extra words
// [R9] Zero extra words: lines back to back
// [R10] Extra words never change visible width
// [R11] Software keeps image inside 81920 bytes
// [R12] Stride counted in 16-bit words
// [R13] Leftmost pixel from most significant bits
module gray_lut_fetch
  import gray_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // AHB-Lite slave
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic [31:0]             HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  // Display buffer bytes
  input  wire logic [7:0]         BYTE_DATA,
  input  wire logic               BYTE_VALID,
  output logic                    BYTE_READY,
  input  wire logic               FRAME_START,
  output logic [WADDR_W-1:0]      LINE_ADDR,
  // Panel pixels
  output logic [GRAY_W-1:0]       PIX_GRAY,
  output logic                    PIX_VALID,
  input  wire logic               PIX_READY
);
  // Reset release
  logic              rst_s1_q;
  logic              rst_s2_q;
  logic              rst_n_i;

  // Bus pipeline and address decode
  logic              addr_take;
  logic              wr_q;
  logic              rd_q;
  logic [9:0]        addr_q;
  logic [31:0]       rd_word;
  logic              hit_ctrl;
  logic              hit_hwidth;
  logic              hit_extra;
  logic              hit_lidx;
  logic              hit_ldata;
  logic              hit_stride;
  logic              hit_laddr;
  logic              we_ctrl;
  logic              we_hwidth;
  logic              we_extra;
  logic              we_lidx;
  logic              we_ldata;

  // Software-visible registers
  bpp_t              bpp_q;
  logic              en_q;
  logic [7:0]        hwidth_q;
  logic [7:0]        extra_q;
  logic [7:0]        lidx_q;
  logic [GRAY_W-1:0] green_q [GRAY_LEVELS];

  // Line addressing
  logic [8:0]        stride;
  logic [WADDR_W-1:0] line_q;
  logic [8:0]        bcnt_q;
  logic [8:0]        line_bytes;
  logic              line_wrap;
  logic              line_last;

  // Unpacker and pixel selection
  logic [7:0]        shift_q;
  logic [3:0]        left_q;
  logic [3:0]        ppb;
  logic [3:0]        pix_code;
  logic [7:0]        shift_next;
  logic [3:0]        code_1;
  logic [3:0]        code_2;
  logic [3:0]        code_4;
  logic [7:0]        shift_1;
  logic [7:0]        shift_2;
  logic [7:0]        shift_4;
  logic              pix_pending;
  logic [GRAY_W-1:0] gray_sel;
  logic              byte_take;
  logic              pix_push;
  logic              fifo_in_ready;
  bpp_t              wr_bpp;
  logic              bpp_ok;

  // Reset release through two flops; assertion still clears all but the FIFO storage
  // at once, only the release waits for the clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n_i = rst_s2_q;

  // Bus address phase; reads take one wait cycle so a just-written value is seen
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = !rd_q;
  assign HRESP     = 1'b0;

  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= addr_take && HWRITE;
      rd_q <= addr_take && !HWRITE;
    end
  end

  // Address is held for the whole data phase, wait state included
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) addr_q <= '0;
    else if (addr_take) addr_q <= HADDR[9:0];
  end

  // Read data is registered in the wait cycle
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) HRDATA <= '0;
    else if (rd_q) HRDATA <= rd_word;
  end

  // Address decode of the latched data-phase address
  assign hit_ctrl   = (addr_q == ADDR_CTRL);
  assign hit_hwidth = (addr_q == ADDR_HWIDTH);
  assign hit_extra  = (addr_q == ADDR_LINE_EXTRA);
  assign hit_lidx   = (addr_q == ADDR_LUT_INDEX);
  assign hit_ldata  = (addr_q == ADDR_LUT_DATA);
  assign hit_stride = (addr_q == ADDR_STRIDE);
  assign hit_laddr  = (addr_q == ADDR_LINE_ADDR);

  // Write strobes in the data phase; LUT writes past entry fifteen are dropped
  assign we_ctrl   = wr_q && hit_ctrl;
  assign we_hwidth = wr_q && hit_hwidth;
  assign we_extra  = wr_q && hit_extra;
  assign we_lidx   = wr_q && hit_lidx;
  assign we_ldata  = wr_q && hit_ldata && (lidx_q < 8'(GRAY_LEVELS)); // [R2]
  assign wr_bpp    = bpp_t'(HWDATA[CTRL_BPP_LSB +: 2]);
  assign bpp_ok    = (wr_bpp != BPP_8); // [R3]

  // Green readback for a LUT index; entries past fifteen read zero
  function automatic logic [GRAY_W-1:0] lut_rd(input logic [7:0] idx);
    lut_rd = (idx < 8'(GRAY_LEVELS)) ? green_q[idx[3:0]] : RST_GREEN;
  endfunction : lut_rd

  // Read mux; unmapped words and reserved bits read zero, and the
  // green nibble comes back where it was written
  assign rd_word =
    hit_ctrl   ? {29'h0, en_q, bpp_q} :
    hit_hwidth ? {24'h0, hwidth_q} :
    hit_extra  ? {24'h0, extra_q} :
    hit_lidx   ? {24'h0, lidx_q} :
    hit_ldata  ? {24'h0, lut_rd(lidx_q), 4'h0} : // [R1]
    hit_stride ? {23'h0, stride} :
    hit_laddr  ? {15'h0, line_q} : 32'h0000_0000;

  // Depth; an 8 bpp request keeps the old depth
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) bpp_q <= RST_BPP;
    else if (we_ctrl && bpp_ok) bpp_q <= wr_bpp; // [R3]
  end

  // Enable is written even when the depth is refused
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) en_q <= RST_EN;
    else if (we_ctrl) en_q <= HWDATA[CTRL_EN_BIT];
  end

  // Visible width in words
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) hwidth_q <= RST_HWIDTH;
    else if (we_hwidth) hwidth_q <= HWDATA[7:0];
  end

  // Extra words per line; the full byte is kept so 0 to 255 all work
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) extra_q <= RST_LINE_EXTRA;
    else if (we_extra) extra_q <= HWDATA[7:0]; // [R8]
  end

  // LUT index; no auto-increment, software rewrites it per entry
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) lidx_q <= RST_LUT_INDEX;
    else if (we_lidx) lidx_q <= HWDATA[7:0];
  end

  // Only the green nibble is kept; red and blue writes are dropped
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < GRAY_LEVELS; i++) green_q[i] <= RST_GREEN;
    end else if (we_ldata) begin
      green_q[lidx_q[3:0]] <= HWDATA[LUT_GREEN_LSB +: GRAY_W]; // [R1] [R2]
    end
  end

  // Stride in 16-bit words: visible width plus extra words;
  // nine bits so two full bytes cannot wrap
  assign stride     = {1'b0, hwidth_q} + {1'b0, extra_q}; // [R8] [R9] [R12]
  // Visible bytes per line depend on the width only
  assign line_bytes = {hwidth_q, 1'b0}; // [R10] [R12]
  // A zero width never closes a line, so the address cannot run away
  assign line_last  = (hwidth_q != 8'h00) && (bcnt_q == line_bytes - 9'd1);
  assign line_wrap  = byte_take && line_last;
  assign LINE_ADDR  = line_q;

  // Line start address advances by one stride per finished line;
  // a frame start wins over a line end in the same cycle
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q <= '0;
      bcnt_q <= '0;
    end else if (FRAME_START) begin
      line_q <= '0;
      bcnt_q <= '0;
    end else if (line_wrap) begin
      line_q <= line_q + WADDR_W'(stride); // [R8] [R9]
      bcnt_q <= '0;
    end else if (byte_take) begin
      bcnt_q <= bcnt_q + 9'd1;
    end
  end

  // Candidate codes and shifts for each depth, leftmost pixel in the MSBs
  assign code_1  = {3'b000, shift_q[7]}; // [R4] [R13]
  assign code_2  = {2'b00, shift_q[7:6]}; // [R5] [R13]
  assign code_4  = shift_q[7:4]; // [R6] [R13]
  assign shift_1 = {shift_q[6:0], 1'b0};
  assign shift_2 = {shift_q[5:0], 2'b00};
  assign shift_4 = {shift_q[3:0], 4'h0};

  // Pixels per byte and code of the leftmost pending pixel
  assign ppb = (bpp_q == BPP_1) ? 4'd8 :
               (bpp_q == BPP_2) ? 4'd4 : 4'd2; // [R4] [R5] [R6]
  assign pix_code = (bpp_q == BPP_1) ? code_1 :
                    (bpp_q == BPP_2) ? code_2 : code_4; // [R4] [R5] [R6]
  assign shift_next = (bpp_q == BPP_1) ? shift_1 :
                      (bpp_q == BPP_2) ? shift_2 : shift_4; // [R13]

  // Pending pixels and the gray level of the leftmost one
  assign pix_pending = (left_q != 4'd0);
  assign gray_sel    = green_q[pix_code]; // [R1] [R2]

  // A byte is taken only once the previous one is fully unpacked
  assign BYTE_READY = en_q && !pix_pending;
  assign byte_take  = BYTE_READY && BYTE_VALID;
  // FIFO back-pressure stalls the unpacker
  assign pix_push   = pix_pending && fifo_in_ready;

  // Unpacker: load a byte, then shift pixels out MSB first
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
      left_q  <= '0;
    end else if (byte_take) begin
      shift_q <= BYTE_DATA;
      left_q  <= ppb; // [R4] [R5] [R6]
    end else if (pix_push) begin
      shift_q <= shift_next; // [R13]
      left_q  <= left_q - 4'd1;
    end
  end

  // Gray levels queue toward the panel; sixteen slots let a slow
  // panel fall two whole 1 bpp bytes behind before bytes stall
  pix_fifo #(
    .W     (GRAY_W),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (rst_n_i),
    .in_valid  (pix_pending),
    .in_ready  (fifo_in_ready),
    .in_data   (gray_sel),
    .out_valid (PIX_VALID),
    .out_ready (PIX_READY),
    .out_data  (PIX_GRAY)
  );
endmodule : gray_lut_fetch
`default_nettype wire

/* File: dv/gray_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module gray_checker
  import gray_pkg::*;
(
  // Clock and reset
  input wire logic               CLK,
  input wire logic               RST_N,
  // Register bus
  input wire logic               HSEL,
  input wire logic [1:0]         HTRANS,
  input wire logic               HWRITE,
  input wire logic               HREADY,
  input wire logic               HREADYOUT,
  input wire logic               HRESP,
  // Byte and pixel streams
  input wire logic               BYTE_VALID,
  input wire logic               BYTE_READY,
  input wire logic               FRAME_START,
  input wire logic [WADDR_W-1:0] LINE_ADDR,
  input wire logic [GRAY_W-1:0]  PIX_GRAY,
  input wire logic               PIX_VALID,
  input wire logic               PIX_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Accepted requests on each side
  wire logic take_a = HSEL & HTRANS[1] & HREADY;
  wire logic take_b = BYTE_VALID & BYTE_READY;
  sequence one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  read_wait_a: assert property (take_a && !HWRITE |=> one_wait) else $error("read wait state wrong");
  write_fast_a: assert property (take_a && HWRITE |=> HREADYOUT) else $error("write stalled");
  okay_resp_a: assert property (HRESP == 1'b0) else $error("bus error response");
  byte_gap_a: assert property (take_b |=> !BYTE_READY [*2]) else $error("byte taken too soon");
  byte_pix_a: assert property (take_b |-> ##[1:3] PIX_VALID) else $error("no pixel after byte");
  pix_hold_a: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_GRAY))
    else $error("pixel dropped while stalled");
  line_zero_a: assert property (FRAME_START |=> LINE_ADDR == {WADDR_W{1'b0}}) else $error("line not reset");
  line_step_a: assert property ($changed(LINE_ADDR) |-> $past(FRAME_START) || $past(take_b))
    else $error("line address moved alone");
endmodule : gray_checker
bind gray_lut_fetch gray_checker i_chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
  .FRAME_START(FRAME_START), .LINE_ADDR(LINE_ADDR), .PIX_GRAY(PIX_GRAY), .PIX_VALID(PIX_VALID),
  .PIX_READY(PIX_READY));
`default_nettype wire

/* File: dv/panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module panel_model
  import gray_pkg::*;
(
  // Clock
  input wire logic              clk,
  // Pixel stream
  input wire logic [GRAY_W-1:0] pix_gray,
  input wire logic              pix_valid,
  output logic                  pix_ready,
  // Full stall from the bench
  input wire logic              stall
);
  logic [GRAY_W-1:0] got[$];
  logic              beat_q = 1'b0;
  // Slow panel takes every other cycle so the FIFO backs up
  always @(posedge clk) begin
    beat_q <= ~beat_q;
    if (pix_valid && pix_ready) got.push_back(pix_gray);
  end
  assign pix_ready = ~stall & beat_q;
endmodule : panel_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import gray_pkg::*;
;
  logic CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, BYTE_VALID = 1'b0, FRAME_START = 1'b0, stall = 1'b0;
  logic [31:0]        HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0]         HTRANS = 2'h0;
  logic [7:0]         BYTE_DATA = 8'h00;
  logic               HREADYOUT, HRESP, BYTE_READY, PIX_VALID, PIX_READY;
  logic [WADDR_W-1:0] LINE_ADDR;
  logic [GRAY_W-1:0]  PIX_GRAY;
  logic [3:0]         green [16];
  int                 err_count = 0, checks_done = 0;
  always #2.5 CLK = ~CLK;
  // Bus ready is the one slave's ready
  gray_lut_fetch i_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .BYTE_DATA(BYTE_DATA), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY), .FRAME_START(FRAME_START),
    .LINE_ADDR(LINE_ADDR), .PIX_GRAY(PIX_GRAY), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY));
  panel_model i_panel (.clk(CLK), .pix_gray(PIX_GRAY), .pix_valid(PIX_VALID), .pix_ready(PIX_READY), .stall(stall));
  task wrap_up;
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Waits for an edge with ready high; readiness is looked at mid-cycle to avoid edge races
  task hs(input logic byte_side, output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (!r) begin
      @(negedge CLK);
      r = byte_side ? (BYTE_READY === 1'b1) : (HREADYOUT === 1'b1);
      d = HRDATA;
      @(posedge CLK);
    end
  endtask : hs
  task ahb(input logic w, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {22'h0, a};
    hs(1'b0, rd);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    hs(1'b0, rd);
  endtask : ahb
  task wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task rdc(input string n, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(n, e, d);
  endtask : rdc
  task send_byte(input logic [7:0] b);
    logic [31:0] x;
    BYTE_DATA <= b;
    BYTE_VALID <= 1'b1;
    hs(1'b1, x);
    BYTE_VALID <= 1'b0;
    @(posedge CLK);
  endtask : send_byte
  task drain(input int n);
    repeat (400) if (i_panel.got.size() < n) @(posedge CLK);
  endtask : drain
  task reg_reset;
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("width", ADDR_HWIDTH, 32'h14);
    rdc("extra", ADDR_LINE_EXTRA, 32'h0);
    rdc("unmapped", 10'h3FC, 32'h0);
    chk("idle ready", 32'h0, {31'h0, BYTE_READY});
  endtask : reg_reset
  // Red and blue carry the inverse of green so a wrong field shows
  task lut_green;
    for (int i = 0; i < 16; i++) begin
      green[i] = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'(i) ^ 4'h9;
      wr(ADDR_LUT_INDEX, 32'(i));
      wr(ADDR_LUT_DATA, {20'h0, ~green[i], green[i], ~green[i]});
      rdc("lut", ADDR_LUT_DATA, {24'h0, green[i], 4'h0});
    end
    // Entry sixteen does not exist; a write there must not alias entry 0
    wr(ADDR_LUT_INDEX, 32'h10);
    wr(ADDR_LUT_DATA, 32'hFFF);
    rdc("lut past 16", ADDR_LUT_DATA, 32'h0);
  endtask : lut_green
  task run_mode(input bpp_t m, input logic [7:0] b, input logic st);
    int w, ppb;
    logic [7:0] s;
    w = 1 << m;
    ppb = 8 / w;
    stall <= st;
    wr(ADDR_CTRL, {29'h0, 1'b1, m});
    send_byte(b);
    send_byte(~b);
    if (st) begin
      repeat (20) @(posedge CLK);
      chk("stalled", 32'h0, 32'(i_panel.got.size()));
      stall <= 1'b0;
    end
    drain(2 * ppb);
    chk("count", 32'(2 * ppb), 32'(i_panel.got.size()));
    for (int k = 0; k < 2 * ppb; k++) begin
      s = ((k < ppb) ? b : ~b) << ((k % ppb) * w);
      chk("gray", {28'h0, green[s >> (8 - w)]}, {28'h0, i_panel.got[k]});
    end
    i_panel.got.delete();
  endtask : run_mode
  task depth_refuse;
    wr(ADDR_CTRL, 32'h7);
    rdc("no 8 bpp", ADDR_CTRL, 32'h6);
  endtask : depth_refuse
  // Small stride keeps the image well inside the buffer
  task stride_lines;
    wr(ADDR_HWIDTH, 32'h1);
    wr(ADDR_LINE_EXTRA, 32'hFF);
    rdc("extra max", ADDR_LINE_EXTRA, 32'hFF);
    rdc("stride", ADDR_STRIDE, 32'h100);
    wr(ADDR_LINE_EXTRA, 32'h0);
    FRAME_START <= 1'b1;
    @(posedge CLK);
    FRAME_START <= 1'b0;
    send_byte(8'h12);
    send_byte(8'h34);
    drain(4);
    rdc("packed line", ADDR_LINE_ADDR, 32'h1);
    wr(ADDR_LINE_EXTRA, 32'h3);
    send_byte(8'h56);
    send_byte(8'h78);
    drain(8);
    rdc("virtual line", ADDR_LINE_ADDR, 32'h5);
    chk("line pixels", 32'h8, 32'(i_panel.got.size()));
    chk("line pin", 32'h5, {15'h0, LINE_ADDR});
    i_panel.got.delete();
  endtask : stride_lines
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    reg_reset;
    lut_green;
    run_mode(BPP_1, 8'hA6, 1'b1);
    run_mode(BPP_2, 8'h1B, 1'b0);
    run_mode(BPP_4, 8'h3C, 1'b0);
    depth_refuse;
    stride_lines;
    wrap_up;
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
